/* File: ssp_slave_port.sv */
// synchronous slave serial port with apb registers
`default_nettype none
`include "ssp_cfg.svh"
module ssp_slave_port
    import ssp_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] shiftTimingIn,
    input wire logic [1:0] serialDataIn,
    output logic [1:0] serialDataOut,
    output logic [1:0] serialDataOe,
    output logic wakeCore,
    output logic takeVector
);
    ssp_state_t s, n;
    logic slave, rxMode, txSel, txRun;
    logic ckNow, dtNow, ckRise, ckFall;
    logic rdAcc, wrAcc, rcFlag, txFlag;
    logic rxDone, txDone, rxWakeReq, ctlWrite;
    logic [3:0] bits, txBits;
    logic [8:0] rxWord;

    // address decode shared by write path and error response
    function automatic logic known(input logic [11:0] a);
        known = (a <= `SSP_ADDR_CORE) && (a[1:0] == 2'b00);
    endfunction

    // character length; both directions pick eight or nine bits
    function automatic logic [3:0] char_bits(input logic nine);
        char_bits = nine ? `SSP_BITS9 : `SSP_BITS8;
    endfunction

    // next state of the whole port
    always_comb begin
        n = s;

        // both pin positions pass two flops before anything reads
        // them; the relocation select only picks synchronised copies
        n.ckMeta = shiftTimingIn;
        n.ckSync = s.ckMeta;
        n.dtMeta = serialDataIn;
        n.dtSync = s.dtMeta;
        ckNow = s.ckSync[s.pinSel[`SSP_PIN_CK]];
        dtNow = s.dtSync[s.pinSel[`SSP_PIN_DT]];

        // edge detect on the synchronised master clock; history
        // resets low, matching the idle clock, so no false edge
        // limitation: moving the clock pin while it is high
        // looks like an edge, so relocate only between words
        n.ckLast = ckNow;
        ckRise = ckNow & ~s.ckLast;
        ckFall = ~ckNow & s.ckLast;

        // slave only with clocked mode, port on and master off
        slave = s.rcCtl[`SSP_RC_PORT_EN] & s.txCtl[`SSP_TX_SYNC]
            & ~s.txCtl[`SSP_TX_MASTER];
        // single receive acts as continuous; either control means receive
        rxMode = s.rcCtl[`SSP_RC_CONT] | s.rcCtl[`SSP_RC_SINGLE];
        // both controls clear selects the transmit direction
        txSel = slave & ~rxMode & s.txCtl[`SSP_TX_EN];
        bits = char_bits(s.rcCtl[`SSP_RC_NINE]);
        txBits = char_bits(s.txCtl[`SSP_TX_NINE]);

        // apb access phase decode; one wait state, then ready
        rdAcc = psel & penable & ~pwrite & ~s.pready;
        wrAcc = psel & penable & pwrite & ~s.pready & known(paddr);
        ctlWrite = wrAcc & (paddr == `SSP_ADDR_RX_CTRL);
        n.pready = psel & penable & ~s.pready;
        n.pslverr = psel & penable & ~s.pready & ~known(paddr);

        // flags are derived from fill state, never stored apart
        rcFlag = (s.rxLevel != `SSP_LVL_EMPTY);
        txFlag = ~s.txBufFull;
        rxWakeReq = rcFlag & s.intEn[`SSP_IE_RC];
        rxDone = 1'b0;
        txDone = 1'b0;
        rxWord = {s.rxShift[7:0], dtNow};
        txRun = txSel & s.txBusy;

        // apb register writes
        if (wrAcc) begin
            case (paddr)
                `SSP_ADDR_RX_CTRL: begin
                    n.rcCtl = pwdata[7:0];
                    // clearing continuous receive drops overrun
                    if (!pwdata[`SSP_RC_CONT]) n.overrun = 1'b0;
                end
                `SSP_ADDR_TX_CTRL: n.txCtl = pwdata[7:0];
                `SSP_ADDR_BAUD: n.baud = pwdata[7:0];
                `SSP_ADDR_INTEN: n.intEn = pwdata[3:0];
                `SSP_ADDR_PINSEL: n.pinSel = pwdata[1:0];
                `SSP_ADDR_CORE: n.sleep = pwdata[`SSP_CORE_SLEEP];
                `SSP_ADDR_TDATA: begin
                    // data goes to shifter first, else to buffer;
                    // a write with both full is dropped
                    if (!s.txBusy) begin
                        n.txShift = {s.txCtl[`SSP_TX_BIT9], pwdata[7:0]};
                        n.txBusy = 1'b1;
                        n.txCnt = 4'h0;
                    end else if (!s.txBufFull) begin
                        n.txBuf = {s.txCtl[`SSP_TX_BIT9], pwdata[7:0]};
                        n.txBufFull = 1'b1;
                    end
                end
                default: ;
            endcase
        end

        // read mux; receive data read pops the fifo
        n.prdata = 32'h0000_0000;
        if (rdAcc) begin
            case (paddr)
                `SSP_ADDR_RX_CTRL: n.prdata[7:0] = {s.rcCtl[7:2],
                    s.overrun, s.rxFifo0[8]};
                `SSP_ADDR_TX_CTRL: n.prdata[7:0] = {s.txCtl[7:2],
                    ~s.txBusy, s.txCtl[0]};
                `SSP_ADDR_BAUD: n.prdata[7:0] = s.baud;
                `SSP_ADDR_RDATA: begin
                    n.prdata[7:0] = s.rxFifo0[7:0];
                    if (rcFlag) begin
                        n.rxFifo0 = s.rxFifo1;
                        n.rxLevel = s.rxLevel - `SSP_LVL_ONE;
                    end
                end
                `SSP_ADDR_INTEN: n.prdata[3:0] = s.intEn;
                `SSP_ADDR_INTFLG: n.prdata[1:0] = {txFlag, rcFlag};
                `SSP_ADDR_PINSEL: n.prdata[1:0] = s.pinSel;
                `SSP_ADDR_CORE: n.prdata[0] = s.sleep;
                default: ;
            endcase
        end

        // receive: sample data on rising edge of master clock, msb
        // first; only slave mode uses the pin clock, so it runs
        // while the core sleeps
        if (slave && rxMode && ckRise) begin
            n.rxShift = rxWord;
            n.rxCnt = s.rxCnt + 4'h1;
            if (s.rxCnt + 4'h1 == bits) begin
                rxDone = 1'b1;
                n.rxCnt = 4'h0;
                // eight-bit words carry no stale top bit
                if (!s.rcCtl[`SSP_RC_NINE]) rxWord[8] = 1'b0;
                // fill level after any pop in this same cycle, so a
                // read and a completion together lose nothing
                if (n.rxLevel == `SSP_LVL_FULL) begin
                    // a full fifo flags overrun; the word is dropped
                    n.overrun = 1'b1;
                end else if (n.rxLevel == `SSP_LVL_EMPTY) begin
                    n.rxFifo0 = rxWord;
                    n.rxLevel = `SSP_LVL_ONE;
                end else begin
                    n.rxFifo1 = rxWord;
                    n.rxLevel = `SSP_LVL_FULL;
                end
            end
        end
        if (!rxMode) n.rxCnt = 4'h0;

        // transmit: lsb first; each falling edge moves to the next
        // bit, so the master samples a settled bit on every rise
        if (txRun && ckFall) begin
            n.txShift = {1'b0, s.txShift[8:1]};
            n.txCnt = s.txCnt + 4'h1;
            if (s.txCnt + 4'h1 == txBits) begin
                txDone = 1'b1;
                n.txCnt = 4'h0;
                // refill from buffer, including a byte written in
                // this very cycle; flag rises as the buffer empties
                if (n.txBufFull) begin
                    n.txShift = n.txBuf;
                    n.txBufFull = 1'b0;
                end else begin
                    n.txBusy = 1'b0;
                end
            end
        end
        // first bit of a loaded word stands before the first rise
        n.dtOut = n.txShift[0];

        // wake and vector follow the pending, enabled flags
        n.wake = s.sleep & (rxWakeReq |
            (txFlag & s.intEn[`SSP_IE_TX] & s.intEn[`SSP_IE_PERIPH]));
        n.vector = n.wake & s.intEn[`SSP_IE_GLOBAL];
        if (n.wake) n.sleep = 1'b0;

        // port disable clears overrun, fifo level, both counters and transmit busy/buffer
        if (!n.rcCtl[`SSP_RC_PORT_EN]) begin
            n.overrun = 1'b0;
            n.rxLevel = `SSP_LVL_EMPTY;
            n.rxCnt = 4'h0;
            n.txCnt = 4'h0;
            n.txBusy = 1'b0;
            n.txBufFull = 1'b0;
        end

        // data pin is driven only in slave transmit direction
        n.dtOe = {2{slave & ~rxMode}} &
            {s.pinSel[`SSP_PIN_DT], ~s.pinSel[`SSP_PIN_DT]};
    end

    // single state register
    always_ff @(posedge core_clk) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // outputs straight from flops
    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign serialDataOut = {s.dtOut, s.dtOut};
    assign serialDataOe = s.dtOe;
    assign wakeCore = s.wake;
    assign takeVector = s.vector;

    // overrun and unit state cleared while the port is off
    AST_OVR_CLR: assert property (@(posedge core_clk) disable iff (srst)
        (s.rcCtl[`SSP_RC_PORT_EN] == 1'b0) |=> !s.overrun)
        else $error("overrun kept with port disabled");
    AST_TX_OFF: assert property (@(posedge core_clk) disable iff (srst)
        (s.rcCtl[`SSP_RC_PORT_EN] == 1'b0) |=> !s.txBusy)
        else $error("transmitter busy with port disabled");

    // a full fifo and a completed word raise overrun
    AST_OVR_SET: assert property (@(posedge core_clk) disable iff (srst)
        rxDone && s.rxLevel == `SSP_LVL_FULL && !rdAcc && !ctlWrite
        |=> s.overrun)
        else $error("overrun not raised on full fifo");

    // receive flag tracks the fifo fill level
    AST_FLAG_EMPTY: assert property (@(posedge core_clk) disable iff (srst)
        (s.rxLevel == `SSP_LVL_EMPTY) |-> !(rcFlag))
        else $error("receive flag with empty fifo");
    AST_FIFO_BOUND: assert property (@(posedge core_clk) disable iff (srst)
        s.rxLevel <= `SSP_LVL_FULL)
        else $error("receive fifo level past its depth");

    // a completed word leaves the flag set unless the receive control is written
    AST_RX_FLAG: assert property (@(posedge core_clk) disable iff (srst)
        rxDone && !ctlWrite |=> rcFlag)
        else $error("receive flag not set by a full word");

    // eight-bit words stored with a clear top bit
    AST_NINE_CLR: assert property (@(posedge core_clk) disable iff (srst)
        rxDone && !s.rcCtl[`SSP_RC_NINE] && s.rxLevel == `SSP_LVL_EMPTY
        && !rdAcc && !ctlWrite |=> !s.rxFifo0[8])
        else $error("stale ninth bit in eight-bit word");

    // wake sources and their enables
    AST_TX_WAKE: assert property (@(posedge core_clk) disable iff (srst)
        s.wake && !$past(rxWakeReq) |-> $past(s.intEn[`SSP_IE_PERIPH]))
        else $error("tx wake without peripheral enable");
    AST_RX_WAKE: assert property (@(posedge core_clk) disable iff (srst)
        s.sleep && rxWakeReq |=> s.wake)
        else $error("receive completion did not wake");
    AST_TX_WAKE_ON: assert property (@(posedge core_clk) disable iff (srst)
        s.sleep && txFlag && s.intEn[`SSP_IE_TX]
        && s.intEn[`SSP_IE_PERIPH] |=> s.wake)
        else $error("transmit flag did not wake");
    AST_VEC: assert property (@(posedge core_clk) disable iff (srst)
        s.vector |-> s.wake && $past(s.intEn[`SSP_IE_GLOBAL]))
        else $error("vector without global enable");
    AST_WAKE_RUN: assert property (@(posedge core_clk) disable iff (srst)
        s.wake |-> !s.sleep)
        else $error("still asleep after wake");

    // shifting only in slave mode
    AST_NOSHIFT: assert property (@(posedge core_clk) disable iff (srst)
        !slave |=> $stable(s.rxCnt) || s.rxCnt == 4'h0)
        else $error("receiver shifted outside slave mode");
    AST_RX_HOLD: assert property (@(posedge core_clk) disable iff (srst)
        !slave |=> $stable(s.rxShift))
        else $error("receive shifter moved outside slave mode");
    AST_CNT9: assert property (@(posedge core_clk) disable iff (srst)
        s.rxCnt <= 4'h8)
        else $error("receive counter past nine bits");
    AST_TX_CNT: assert property (@(posedge core_clk) disable iff (srst)
        s.txCnt <= 4'h8)
        else $error("transmit counter past nine bits");

    // transmit buffering
    AST_WR_FLAG: assert property (@(posedge core_clk) disable iff (srst)
        wrAcc && paddr == `SSP_ADDR_TDATA && s.txBusy
        && !s.txBufFull && s.rcCtl[`SSP_RC_PORT_EN] |=> s.txBufFull)
        else $error("buffer not filled by write");
    AST_TX_REFILL: assert property (@(posedge core_clk) disable iff (srst)
        txDone && s.txBufFull && n.rcCtl[`SSP_RC_PORT_EN]
        |=> s.txBusy && !s.txBufFull)
        else $error("buffered byte not moved to shifter");

    // data pin driven only in the transmit direction
    AST_OE_DIR: assert property (@(posedge core_clk) disable iff (srst)
        s.dtOe != 2'b00 |-> $past(slave) && !$past(rxMode))
        else $error("data pin driven while receiving");

    // apb ready never in setup and never two cycles long
    AST_PREADY: assert property (@(posedge core_clk) disable iff (srst)
        psel && !penable |=> !s.pready)
        else $error("ready in setup phase");
    AST_RDY_PULSE: assert property (@(posedge core_clk) disable iff (srst)
        s.pready |=> !s.pready)
        else $error("ready held longer than one cycle");
endmodule
`default_nettype wire

/* File: ssp_cfg.svh */
// register map and field positions of the slave serial port
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH
`define SSP_ADDR_RX_CTRL 12'h000
`define SSP_ADDR_TX_CTRL 12'h004
`define SSP_ADDR_BAUD 12'h008
`define SSP_ADDR_RDATA 12'h00C
`define SSP_ADDR_TDATA 12'h010
`define SSP_ADDR_INTEN 12'h014
`define SSP_ADDR_INTFLG 12'h018
`define SSP_ADDR_PINSEL 12'h01C
`define SSP_ADDR_CORE 12'h020
// receive status/control fields
`define SSP_RC_PORT_EN 7
`define SSP_RC_NINE 6
`define SSP_RC_SINGLE 5
`define SSP_RC_CONT 4
`define SSP_RC_OVR 1
`define SSP_RC_BIT9 0
// transmit status/control fields
`define SSP_TX_MASTER 7
`define SSP_TX_NINE 6
`define SSP_TX_EN 5
`define SSP_TX_SYNC 4
`define SSP_TX_IDLE 1
`define SSP_TX_BIT9 0
// interrupt enable fields
`define SSP_IE_RC 0
`define SSP_IE_TX 1
`define SSP_IE_PERIPH 2
`define SSP_IE_GLOBAL 3
// core control: sleep request
`define SSP_CORE_SLEEP 0
// relocation select bits
`define SSP_PIN_DT 0
`define SSP_PIN_CK 1
`define SSP_BITS8 4'h8
`define SSP_BITS9 4'h9
`define SSP_FIFO_DEPTH 2
// receive fifo fill levels
`define SSP_LVL_EMPTY 2'h0
`define SSP_LVL_ONE 2'h1
`define SSP_LVL_FULL 2'h2
`endif

/* File: ssp_pkg.sv */
// types of the slave serial port
`default_nettype none
package ssp_pkg;
    typedef enum logic [1:0] {SSP_IDLE, SSP_SHIFT, SSP_DONE} ssp_mode_t;
    typedef struct packed {
        logic [1:0] ckMeta;
        logic [1:0] ckSync;
        logic ckLast;
        logic [1:0] dtMeta;
        logic [1:0] dtSync;
        logic [1:0] dtOe;
        logic [7:0] rcCtl;
        logic [7:0] txCtl;
        logic [7:0] baud;
        logic [3:0] intEn;
        logic [1:0] pinSel;
        logic sleep;
        logic [8:0] rxShift;
        logic [3:0] rxCnt;
        logic [8:0] rxFifo0;
        logic [8:0] rxFifo1;
        logic [1:0] rxLevel;
        logic overrun;
        logic [8:0] txShift;
        logic [3:0] txCnt;
        logic txBusy;
        logic [8:0] txBuf;
        logic txBufFull;
        logic dtOut;
        ssp_mode_t txMode;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic wake;
        logic vector;
    } ssp_state_t;
endpackage
`default_nettype wire

/* File: ssp_ext_master.sv */
// external master model: drives shift clock and data into the port
`default_nettype none
module ssp_ext_master (
    output logic ck,
    output logic dOut,
    input wire logic dIn
);
    timeunit 1ns;
    timeprecision 1ns;
    // clock rests low outside words
    initial begin
        ck = 1'b0;
        dOut = 1'b1;
    end
    // one word at a 320 ns period; bits seen on the line land first in bit 0
    task automatic xfer(input int n, input logic [8:0] tx,
        output logic [8:0] rx);
        rx = '0;
        #13;
        for (int k = 0; k < n; k++) begin
            dOut = tx[n-1-k];
            #160 ck = 1'b1;
            rx[k] = dIn;
            #160 ck = 1'b0;
        end
        dOut = ~dOut; // released line must not hold a stale bit
        #1280;
    endtask
endmodule
`default_nettype wire

/* File: tb_sync_slave_serial_port.sv */
// bench for the slave serial port: apb tasks and scenarios
`default_nettype none
`include "ssp_cfg.svh"
module tb_sync_slave_serial_port;
    import ssp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, srst, psel, penable, pwrite, pready, pslverr, err;
    logic wakeCore, takeVector, ck, mDat, sel, sawW, sawV;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] serialDataOut, serialDataOe;
    logic [8:0] got;
    wire logic dLine = serialDataOe[sel] ? serialDataOut[sel] : mDat;
    int n_fail = 0;
    int num_checks = 0;
    ssp_slave_port DUT (.core_clk(core_clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .shiftTimingIn(sel ? {ck, 1'b0} : {1'b0, ck}),
        .serialDataIn({dLine, dLine}), .serialDataOut(serialDataOut),
        .serialDataOe(serialDataOe), .wakeCore(wakeCore),
        .takeVector(takeVector));
    ssp_ext_master master (.ck(ck), .dOut(mDat), .dIn(dLine));
    // 25 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // wake pulses are short, so latch them
    always @(posedge core_clk) begin
        if (wakeCore === 1'b1) sawW <= 1'b1;
        if (takeVector === 1'b1) sawV <= 1'b1;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e,
        input logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    // one transfer, request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            n_fail++;
            close_out();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    // set up receive, one byte, unmapped access
    task automatic rx_basic();
        apb(1, `SSP_ADDR_TX_CTRL, 32'h0000_0010);
        apb(1, `SSP_ADDR_INTEN, 32'h0000_0001);
        apb(1, `SSP_ADDR_RX_CTRL, 32'h0000_00B0);
        master.xfer(8, 9'h0C6, got);
        apb(0, `SSP_ADDR_INTFLG, 0);
        cmp("rcflag", 1, {31'h0, rd[0]});
        apb(0, `SSP_ADDR_RDATA, 0);
        cmp("rdata", 32'h0000_00C6, {24'h0, rd[7:0]});
        apb(0, `SSP_ADDR_INTFLG, 0);
        cmp("rcflag", 0, {31'h0, rd[0]});
        apb(0, 12'h0FC, 0);
        cmp("slverr", 1, {31'h0, err});
    endtask
    // nine bits on the relocated pins
    task automatic rx_nine();
        sel <= 1'b1;
        apb(1, `SSP_ADDR_PINSEL, 32'h0000_0003);
        apb(1, `SSP_ADDR_RX_CTRL, 32'h0000_00D0);
        master.xfer(9, 9'h1A5, got);
        apb(0, `SSP_ADDR_RX_CTRL, 0);
        cmp("ninth", 1, {31'h0, rd[0]});
        apb(0, `SSP_ADDR_RDATA, 0);
        cmp("rdata9", 32'h0000_00A5, {24'h0, rd[7:0]});
        apb(1, `SSP_ADDR_PINSEL, 0);
        sel <= 1'b0;
    endtask
    // three words into a two-deep fifo
    task automatic rx_overrun();
        apb(1, `SSP_ADDR_RX_CTRL, 32'h0000_0090);
        master.xfer(8, 9'h011, got);
        master.xfer(8, 9'h022, got);
        master.xfer(8, 9'h033, got);
        apb(0, `SSP_ADDR_RX_CTRL, 0);
        cmp("overrun", 1, {31'h0, rd[1]});
        apb(0, `SSP_ADDR_RDATA, 0);
        cmp("rdata", 32'h0000_0011, {24'h0, rd[7:0]});
        apb(0, `SSP_ADDR_RDATA, 0);
        cmp("rdata", 32'h0000_0022, {24'h0, rd[7:0]});
        apb(1, `SSP_ADDR_RX_CTRL, 32'h0000_0080);
        apb(0, `SSP_ADDR_RX_CTRL, 0);
        cmp("overrun", 0, {31'h0, rd[1]});
    endtask
    // receive while asleep wakes the core and takes the vector
    task automatic rx_sleep();
        apb(1, `SSP_ADDR_INTEN, 32'h0000_0009);
        apb(1, `SSP_ADDR_RX_CTRL, 32'h0000_0090);
        sawW <= 1'b0;
        sawV <= 1'b0;
        apb(1, `SSP_ADDR_CORE, 32'h0000_0001);
        master.xfer(8, 9'h05A, got);
        cmp("wake", 3, {30'h0, sawW, sawV});
        apb(0, `SSP_ADDR_CORE, 0);
        cmp("sleep", 0, {31'h0, rd[0]});
        apb(0, `SSP_ADDR_RDATA, 0);
        cmp("rdata", 32'h0000_005A, {24'h0, rd[7:0]});
    endtask
    // two words queued, then transmit while asleep
    task automatic tx_sleep();
        apb(1, `SSP_ADDR_RX_CTRL, 32'h0000_0080);
        apb(1, `SSP_ADDR_TX_CTRL, 32'h0000_0030);
        apb(1, `SSP_ADDR_INTEN, 32'h0000_0006);
        cmp("oe", 1, {30'h0, serialDataOe});
        apb(1, `SSP_ADDR_TDATA, 32'h0000_003C);
        apb(1, `SSP_ADDR_TDATA, 32'h0000_0096);
        apb(0, `SSP_ADDR_INTFLG, 0);
        cmp("txflag", 0, {31'h0, rd[1]});
        sawW <= 1'b0;
        apb(1, `SSP_ADDR_CORE, 32'h0000_0001);
        master.xfer(8, 9'h000, got);
        cmp("txword", 32'h0000_003C, {24'h0, got[7:0]});
        cmp("txwake", 1, {31'h0, sawW});
        apb(0, `SSP_ADDR_INTFLG, 0);
        cmp("txflag", 1, {31'h0, rd[1]});
        apb(1, `SSP_ADDR_TDATA, 32'h0000_000F);
        apb(0, `SSP_ADDR_INTFLG, 0);
        cmp("txflag", 0, {31'h0, rd[1]});
        master.xfer(8, 9'h000, got);
        cmp("txword", 32'h0000_0096, {24'h0, got[7:0]});
    endtask
    // reset, then the scenarios in turn
    initial begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        sel = 1'b0;
        sawW = 1'b0;
        sawV = 1'b0;
        repeat (20) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        rx_basic();
        rx_nine();
        rx_overrun();
        rx_sleep();
        tx_sleep();
        close_out();
    end
endmodule
`default_nettype wire
